// file: verilog/ep_tx_pkg.sv
package ep_tx_pkg;
	localparam logic [11:0] EPR_OFFSET = 12'h000;
	localparam logic [11:0] CTRL_OFFSET = 12'h004;
	localparam logic [11:0] EVT_OFFSET = 12'h008;
	localparam int DONE_POS = 7;
	localparam int TOG_POS = 6;
	localparam int STAT_POS = 4;
	localparam int EPNUM_POS = 0;
	localparam int ISO_POS = 0;
	localparam int CTRLEP_POS = 1;
	localparam int DBUF_POS = 2;
	localparam int MASK_POS = 3;
	localparam logic [15:0] EPR_RESET = 16'h0000;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [1:0] HS_DISABLED = 2'h0;
	localparam logic [1:0] HS_STALL = 2'h1;
	localparam logic [1:0] HS_NAK = 2'h2;
	localparam logic [1:0] HS_VALID = 2'h3;
	typedef enum logic [2:0] {
		EV_IDLE = 3'h1,
		EV_APPLY = 3'h2,
		EV_HOLD = 3'h4
	} ev_state_t;
	typedef enum logic [2:0] {
		TX_ACKED = 3'h0,
		TX_SENT_ISO = 3'h1,
		TX_SETUP = 3'h2,
		TX_NAKED = 3'h3,
		TX_ERROR = 3'h4
	} tx_event_t;
endpackage : ep_tx_pkg

// file: verilog/ep_tx_status.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - set transfer-done on each successful IN transaction; software can only clear
// - endpoint irq always on done; generic irq when mask bit set
// - nak, stall, protocol error or toggle mismatch never set done
// - writing zero clears done, writing one keeps it
// - toggle bit names next data pid; flips on host ACK
// - control endpoint forces toggle to one on SETUP
// - isochronous sends DATA0 only; toggle flips after each packet sent
// - double-buffered endpoints use toggle for buffer swapping too
// - writing one inverts toggle, zero keeps it
// - each handshake bit inverts on written one, keeps on zero
// - after good IN or control SETUP, handshake becomes NAK
// - double-buffered bulk handshake follows buffer availability
// - isochronous handshake untouched by hardware; only VALID or DISABLED (a write can still set any of the four codes)
// - four-bit endpoint number field selects transactions; set before enabling
// - handshake codes: 00 disabled, 01 stall, 10 nak, 11 valid
module ep_tx_status
	import ep_tx_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TX_EVT_VALID,
	input wire logic [2:0] TX_EVT_KIND,
	input wire logic [3:0] TX_EVT_ENDP,
	input wire logic BUF_AVAIL,
	output logic [1:0] TX_HANDSHAKE,
	output logic TX_PID_DATA1,
	output logic TX_BUF_SEL,
	output logic EP_IRQ,
	output logic GEN_IRQ
);
	logic [15:0] epr_r;
	logic [3:0] ctrl_r;
	logic ev_pending_r;
	logic [2:0] ev_kind_r;
	ev_state_t ev_state_r;
	logic apb_wr;
	logic apb_rd;
	logic hit_ep;

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
		is_reg = (a == off);
	endfunction : is_reg

	// writes land at the edge where the master samples ready high
	assign apb_wr = PSEL && PENABLE && PWRITE && PREADY;
	assign apb_rd = PSEL && PENABLE && !PWRITE && !PREADY;
	assign hit_ep = TX_EVT_VALID && (TX_EVT_ENDP == epr_r[EPNUM_POS +: 4]);

	// one wait state: ready answers the cycle after the access phase starts
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PSLVERR <= 1'b0;
			if (PSEL && PENABLE && !PREADY) begin
				PSLVERR <= !(is_reg(PADDR, EPR_OFFSET) || is_reg(PADDR, CTRL_OFFSET)
					|| is_reg(PADDR, EVT_OFFSET));
			end
			if (apb_rd) begin
				if (is_reg(PADDR, EPR_OFFSET)) begin
					PRDATA <= {16'h0, epr_r};
				end else if (is_reg(PADDR, CTRL_OFFSET)) begin
					PRDATA <= {28'h0, ctrl_r};
				end else if (is_reg(PADDR, EVT_OFFSET)) begin
					PRDATA <= {28'h0, ev_kind_r, ev_pending_r};
				end else begin
					PRDATA <= 32'h0;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r <= CTRL_RESET;
		end else if (apb_wr && is_reg(PADDR, CTRL_OFFSET)) begin
			ctrl_r <= PWDATA[3:0];
		end
	end

	// transaction events are captured, then applied one cycle later
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ev_state_r <= EV_IDLE;
			ev_pending_r <= 1'b0;
			ev_kind_r <= TX_ACKED;
		end else begin
			case (ev_state_r)
				EV_IDLE: begin
					if (hit_ep) begin
						ev_state_r <= EV_APPLY;
						ev_pending_r <= 1'b1;
						ev_kind_r <= TX_EVT_KIND;
					end
				end
				EV_APPLY: begin
					ev_state_r <= EV_HOLD;
					ev_pending_r <= 1'b0;
				end
				EV_HOLD: begin
					ev_state_r <= EV_IDLE;
				end
				default: begin
					ev_state_r <= EV_IDLE;
				end
			endcase
		end
	end

	logic iso;
	logic ctl;
	logic dbl;
	logic good_in;
	logic setup_ev;
	logic set_done;
	assign iso = ctrl_r[ISO_POS];
	assign ctl = ctrl_r[CTRLEP_POS];
	assign dbl = ctrl_r[DBUF_POS];
	assign good_in = (ev_state_r == EV_APPLY) &&
		((ev_kind_r == TX_ACKED) || (iso && ev_kind_r == TX_SENT_ISO));
	assign setup_ev = (ev_state_r == EV_APPLY) && ctl && (ev_kind_r == TX_SETUP);
	assign set_done = good_in;

	logic ep_wr;
	assign ep_wr = apb_wr && is_reg(PADDR, EPR_OFFSET);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			epr_r <= EPR_RESET;
		end else begin
			if (ep_wr) begin
				epr_r[EPNUM_POS +: 4] <= PWDATA[EPNUM_POS +: 4];
				if (!PWDATA[DONE_POS]) begin
					epr_r[DONE_POS] <= 1'b0;
				end
			end
			if (set_done) begin
				epr_r[DONE_POS] <= 1'b1;
			end
			if (setup_ev) begin
				epr_r[TOG_POS] <= 1'b1;
			end else if (good_in) begin
				epr_r[TOG_POS] <= ~epr_r[TOG_POS] ^ (ep_wr && PWDATA[TOG_POS]);
			end else if (ep_wr) begin
				epr_r[TOG_POS] <= epr_r[TOG_POS] ^ PWDATA[TOG_POS];
			end
			if ((good_in || setup_ev) && !iso && !(dbl && !ctl)) begin
				epr_r[STAT_POS +: 2] <= HS_NAK;
			end else if ((good_in || setup_ev) && dbl && !ctl && !iso) begin
				epr_r[STAT_POS +: 2] <= BUF_AVAIL ? HS_VALID : HS_NAK;
			end else if (ep_wr) begin
				epr_r[STAT_POS +: 2] <= epr_r[STAT_POS +: 2] ^ PWDATA[STAT_POS +: 2];
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			TX_HANDSHAKE <= HS_DISABLED;
			TX_PID_DATA1 <= 1'b0;
			TX_BUF_SEL <= 1'b0;
			EP_IRQ <= 1'b0;
			GEN_IRQ <= 1'b0;
		end else begin
			TX_HANDSHAKE <= epr_r[STAT_POS +: 2];
			TX_PID_DATA1 <= iso ? 1'b0 : epr_r[TOG_POS];
			TX_BUF_SEL <= epr_r[TOG_POS];
			EP_IRQ <= epr_r[DONE_POS];
			GEN_IRQ <= epr_r[DONE_POS] && ctrl_r[MASK_POS];
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence good_in_s;
		good_in && !setup_ev;
	endsequence

	sequence capture_s;
		ev_state_r == EV_IDLE && hit_ep;
	endsequence

	sequence apply_s;
		ev_state_r == EV_APPLY ##1 ev_state_r == EV_HOLD ##1 ev_state_r == EV_IDLE;
	endsequence

	done_set_a: assert property (set_done |=> epr_r[DONE_POS])
		else $error("done not set after good transfer");
	irq_follow_a: assert property (epr_r[DONE_POS] |=> EP_IRQ)
		else $error("endpoint irq missing");
	gen_mask_a: assert property (GEN_IRQ |-> $past(ctrl_r[MASK_POS]))
		else $error("generic irq without mask");
	no_err_set_a: assert property ((ev_state_r == EV_APPLY && ev_kind_r == TX_NAKED
		&& !$past(epr_r[DONE_POS]) && !epr_r[DONE_POS]) |=> !epr_r[DONE_POS])
		else $error("done set by failed transaction");
	done_clear_a: assert property ((ep_wr && !PWDATA[DONE_POS] && !set_done)
		|=> !epr_r[DONE_POS])
		else $error("done not cleared");
	tog_ack_a: assert property (good_in_s and (!ep_wr)
		|=> epr_r[TOG_POS] != $past(epr_r[TOG_POS]))
		else $error("toggle not flipped");
	setup_tog_a: assert property (setup_ev |=> epr_r[TOG_POS])
		else $error("setup did not force data1");
	iso_pid_a: assert property (iso |=> !TX_PID_DATA1)
		else $error("iso sent data1");
	sw_tog_a: assert property ((ep_wr && PWDATA[TOG_POS] && !good_in && !setup_ev)
		|=> epr_r[TOG_POS] != $past(epr_r[TOG_POS]))
		else $error("write one did not invert toggle");
	nak_after_a: assert property ((good_in && !iso && !dbl) |=> epr_r[STAT_POS +: 2] == HS_NAK
		##1 TX_HANDSHAKE == HS_NAK)
		else $error("handshake not nak after transfer");
	iso_stat_a: assert property ((iso && !ep_wr) |=> $stable(epr_r[STAT_POS +: 2]))
		else $error("iso handshake changed by hardware");

	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	ready_after_a: assert property ((PSEL && PENABLE && !PREADY) |=> PREADY)
		else $error("ready missing after access phase");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error response without ready");
	unmapped_a: assert property ((PSEL && PENABLE && !PREADY && !is_reg(PADDR, EPR_OFFSET)
		&& !is_reg(PADDR, CTRL_OFFSET) && !is_reg(PADDR, EVT_OFFSET)) |=> PSLVERR)
		else $error("unmapped access without error");
	ctrl_write_a: assert property ((apb_wr && is_reg(PADDR, CTRL_OFFSET))
		|=> ctrl_r == $past(PWDATA[3:0]))
		else $error("control write lost");
	ctrl_hold_a: assert property (!(apb_wr && is_reg(PADDR, CTRL_OFFSET)) |=> $stable(ctrl_r))
		else $error("control changed without write");
	rd_ep_a: assert property ((apb_rd && is_reg(PADDR, EPR_OFFSET))
		|=> PRDATA == {16'h0, $past(epr_r)})
		else $error("endpoint read data wrong");
	rd_ctrl_a: assert property ((apb_rd && is_reg(PADDR, CTRL_OFFSET)) |=> PRDATA[31:4] == 28'h0)
		else $error("control read upper bits set");

	num_write_a: assert property (ep_wr
		|=> epr_r[EPNUM_POS +: 4] == $past(PWDATA[EPNUM_POS +: 4]))
		else $error("endpoint number write lost");
	num_hold_a: assert property (!ep_wr |=> $stable(epr_r[EPNUM_POS +: 4]))
		else $error("endpoint number changed");
	miss_ep_a: assert property ((ev_state_r == EV_IDLE && TX_EVT_VALID
		&& TX_EVT_ENDP != epr_r[EPNUM_POS +: 4]) |=> ev_state_r == EV_IDLE)
		else $error("foreign endpoint event taken");

	done_keep_a: assert property ((epr_r[DONE_POS]
		&& !(ep_wr && !PWDATA[DONE_POS])) |=> epr_r[DONE_POS])
		else $error("done lost without clear");
	done_only_a: assert property ((!epr_r[DONE_POS] && !set_done) |=> !epr_r[DONE_POS])
		else $error("done set without good transfer");
	err_no_set_a: assert property ((ev_state_r == EV_APPLY && ev_kind_r == TX_ERROR
		&& !epr_r[DONE_POS]) |=> !epr_r[DONE_POS])
		else $error("done set by error");

	gen_irq_a: assert property ((epr_r[DONE_POS] && ctrl_r[MASK_POS]) |=> GEN_IRQ)
		else $error("generic irq missing");
	no_gen_a: assert property (!ctrl_r[MASK_POS] |=> !GEN_IRQ)
		else $error("generic irq while masked");
	irq_low_a: assert property (!epr_r[DONE_POS] |=> !EP_IRQ)
		else $error("endpoint irq without done");

	tog_hold_a: assert property ((!good_in && !setup_ev
		&& !(ep_wr && PWDATA[TOG_POS])) |=> $stable(epr_r[TOG_POS]))
		else $error("toggle changed without cause");
	iso_tog_a: assert property ((good_in && iso && !ep_wr)
		|=> epr_r[TOG_POS] != $past(epr_r[TOG_POS]))
		else $error("iso toggle not flipped");
	pid_follow_a: assert property (!$past(iso) |-> TX_PID_DATA1 == $past(epr_r[TOG_POS]))
		else $error("pid output wrong");
	buf_sel_a: assert property (TX_BUF_SEL == $past(epr_r[TOG_POS]))
		else $error("buffer select wrong");

	stat_flip_a: assert property ((ep_wr && !good_in && !setup_ev)
		|=> epr_r[STAT_POS +: 2] == ($past(epr_r[STAT_POS +: 2]) ^ $past(PWDATA[STAT_POS +: 2])))
		else $error("handshake write did not invert");
	stat_hold_a: assert property ((!ep_wr && !good_in && !setup_ev) |=> $stable(epr_r[STAT_POS +: 2]))
		else $error("handshake changed without cause");
	setup_nak_a: assert property ((setup_ev && !iso) |=> epr_r[STAT_POS +: 2] == HS_NAK)
		else $error("handshake not nak after setup");
	dbl_avail_a: assert property ((good_in && dbl && !ctl && !iso && BUF_AVAIL)
		|=> epr_r[STAT_POS +: 2] == HS_VALID)
		else $error("double buffer handshake not valid");
	dbl_busy_a: assert property ((good_in && dbl && !ctl && !iso && !BUF_AVAIL)
		|=> epr_r[STAT_POS +: 2] == HS_NAK)
		else $error("double buffer handshake not nak");
	hs_out_a: assert property (TX_HANDSHAKE == $past(epr_r[STAT_POS +: 2]))
		else $error("handshake output wrong");

	ev_walk_a: assert property (capture_s |=> apply_s)
		else $error("event walk broken");
	ev_kind_a: assert property (capture_s |=> ev_kind_r == $past(TX_EVT_KIND))
		else $error("event kind not captured");
	ev_onehot_a: assert property ($onehot(ev_state_r))
		else $error("event state not one-hot");
	ev_pending_a: assert property ((ev_state_r == EV_APPLY) |-> ev_pending_r)
		else $error("pending flag missing");
endmodule : ep_tx_status

// file: bench/usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model
	import ep_tx_pkg::*;
(
	input wire logic CLK,
	output logic TX_EVT_VALID,
	output logic [2:0] TX_EVT_KIND,
	output logic [3:0] TX_EVT_ENDP,
	output logic BUF_AVAIL
);
	initial begin
		TX_EVT_VALID = 1'b0;
		TX_EVT_KIND = 3'h7;
		TX_EVT_ENDP = 4'hf;
		BUF_AVAIL = 1'b0;
	end
	// one transaction result, then released lines and the minimum spacing
	task send(input tx_event_t k, input logic [3:0] e);
		@(posedge CLK);
		TX_EVT_VALID <= 1'b1;
		TX_EVT_KIND <= k;
		TX_EVT_ENDP <= e;
		@(posedge CLK);
		TX_EVT_VALID <= 1'b0;
		TX_EVT_KIND <= ~k;
		TX_EVT_ENDP <= ~e;
		repeat (3) @(posedge CLK);
	endtask : send
	task avail(input logic b);
		@(posedge CLK);
		BUF_AVAIL <= b;
		repeat (3) @(posedge CLK);
	endtask : avail
endmodule : usb_host_model

// file: bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module tb_top
	import ep_tx_pkg::*;
;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, q;
	logic [2:0] TX_EVT_KIND;
	logic [3:0] TX_EVT_ENDP;
	logic [1:0] TX_HANDSHAKE;
	logic PREADY, PSLVERR, err, TX_EVT_VALID, BUF_AVAIL, TX_PID_DATA1, TX_BUF_SEL, EP_IRQ, GEN_IRQ;
	int num_errors = 0;
	int comparisons = 0;
	always #5 CLK = ~CLK;
	ep_tx_status i_ep_tx_status (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .TX_EVT_VALID(TX_EVT_VALID), .TX_EVT_KIND(TX_EVT_KIND),
		.TX_EVT_ENDP(TX_EVT_ENDP), .BUF_AVAIL(BUF_AVAIL), .TX_HANDSHAKE(TX_HANDSHAKE),
		.TX_PID_DATA1(TX_PID_DATA1), .TX_BUF_SEL(TX_BUF_SEL), .EP_IRQ(EP_IRQ), .GEN_IRQ(GEN_IRQ));
	usb_host_model i_usb_host_model (.CLK(CLK), .TX_EVT_VALID(TX_EVT_VALID),
		.TX_EVT_KIND(TX_EVT_KIND), .TX_EVT_ENDP(TX_EVT_ENDP), .BUF_AVAIL(BUF_AVAIL));
	task results;
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			num_errors++;
			results();
		end
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task rc(input logic [11:0] a, input logic [15:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("reg", {16'h0, e}, q)
	endtask : rc
	initial begin
		repeat (10) @(posedge CLK);
		RST_B <= 1'b1;
		rc(EPR_OFFSET, EPR_RESET);
		`CHK("hs", HS_DISABLED, TX_HANDSHAKE)
		apb(1'b1, EPR_OFFSET, 32'h75);
		rc(EPR_OFFSET, 16'h75);
		`CHK("hs", HS_VALID, TX_HANDSHAKE)
		i_usb_host_model.send(TX_ACKED, 4'h5);
		rc(EPR_OFFSET, 16'ha5);
		`CHK("pid", 1'b0, TX_PID_DATA1)
		`CHK("hs", HS_NAK, TX_HANDSHAKE)
		`CHK("irq", 1'b1, EP_IRQ)
		apb(1'b1, CTRL_OFFSET, 32'h8);
		rc(CTRL_OFFSET, 16'h8);
		`CHK("gen", 1'b1, GEN_IRQ)
		apb(1'b1, EPR_OFFSET, 32'h85);
		rc(EPR_OFFSET, 16'ha5);
		apb(1'b1, EPR_OFFSET, 32'h05);
		rc(EPR_OFFSET, 16'h25);
		`CHK("gen", 1'b0, GEN_IRQ)
		i_usb_host_model.send(TX_NAKED, 4'h5);
		i_usb_host_model.send(TX_ERROR, 4'h5);
		i_usb_host_model.send(TX_ACKED, 4'h3);
		rc(EPR_OFFSET, 16'h25);
		apb(1'b1, CTRL_OFFSET, 32'h2);
		apb(1'b1, EPR_OFFSET, 32'h15);
		i_usb_host_model.send(TX_SETUP, 4'h5);
		`CHK("pid", 1'b1, TX_PID_DATA1)
		`CHK("hs", HS_NAK, TX_HANDSHAKE)
		apb(1'b1, CTRL_OFFSET, 32'h1);
		apb(1'b1, EPR_OFFSET, 32'h15);
		i_usb_host_model.send(TX_SENT_ISO, 4'h5);
		rc(EVT_OFFSET, 16'h2);
		apb(1'b0, EPR_OFFSET, 32'h0);
		`CHK("tog", 1'b0, q[TOG_POS])
		`CHK("pid", 1'b0, TX_PID_DATA1)
		`CHK("hs", HS_VALID, TX_HANDSHAKE)
		apb(1'b1, CTRL_OFFSET, 32'h4);
		apb(1'b1, EPR_OFFSET, 32'h95);
		i_usb_host_model.avail(1'b1);
		i_usb_host_model.send(TX_ACKED, 4'h5);
		`CHK("hs", HS_VALID, TX_HANDSHAKE)
		apb(1'b0, EPR_OFFSET, 32'h0);
		`CHK("tog", 1'b1, q[TOG_POS])
		`CHK("buf", 1'b1, TX_BUF_SEL)
		i_usb_host_model.avail(1'b0);
		i_usb_host_model.send(TX_ACKED, 4'h5);
		`CHK("hs", HS_NAK, TX_HANDSHAKE)
		apb(1'b0, 12'h00c, 32'h0);
		`CHK("err", 1'b1, err)
		`CHK("dat", 32'h0, q)
		results();
	end
endmodule : tb_top
